// >>> inc/pgrr_params.svh
// constants for the power-good and register-reset block
`ifndef PGRR_PARAMS_SVH
`define PGRR_PARAMS_SVH

// -----------------------------------------------------------------------------
// rails and widths
// -----------------------------------------------------------------------------
`define PGRR_NUM_RAILS      6
`define PGRR_NUM_FAULTS     12
`define PGRR_VCODE_W        7
`define PGRR_DISCH_W        2

// -----------------------------------------------------------------------------
// reset values
// -----------------------------------------------------------------------------
`define PGRR_VCODE_RST      7'h00
`define PGRR_DISCH_RST      2'h1
`define PGRR_PWM_RST        4'h0
`define PGRR_MASK_RST       12'h000

// -----------------------------------------------------------------------------
// rail indices and configuration codes
// -----------------------------------------------------------------------------
`define PGRR_R1             0
`define PGRR_R2             1
`define PGRR_R3             2
`define PGRR_R4             3
`define PGRR_R5             4
`define PGRR_R6             5
`define PGRR_MEM_LP         1'b1

`endif

// >>> inc/pgrr_pkg.sv
// types for the power-good and register-reset block
package pgrr_pkg;

    // -------------------------------------------------------------------------
    // sequencer states
    // -------------------------------------------------------------------------
    typedef enum logic [2:0]
    {
        PGRR_OFF    = 3'b001,
        PGRR_RESUME = 3'b010,
        PGRR_ACTIVE = 3'b100
    } pgrr_state_e;

endpackage

// >>> hdl/pgrr_sync.sv
// two-stage synchroniser bank
module pgrr_sync
#(
    parameter int WIDTH = 1
)
(
    input  wire logic             I_CLK,
    input  wire logic             I_RESET,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_ff;

    // -------------------------------------------------------------------------
    // capture
    // -------------------------------------------------------------------------
    // parent reads only the second stage; the first may be metastable
    always_ff @(posedge I_CLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            meta_ff <= '0;
            o_sync  <= '0;
        end
        else
        begin
            meta_ff <= i_async;
            o_sync  <= meta_ff;
        end
    end

endmodule // pgrr_sync

// >>> hdl/pgrr_top.sv
// power-good qualification and global register reset logic
// -----------------------------------------------------------------------------
// Overview of operation
// RULE_01 - enabling a rail disconnects its discharge resistor without host action
// RULE_02 - each rail's discharge value is selectable by control register bits
// RULE_03 - resume good needs lockout clear, enable, thermal high, rails one, four, five
// RULE_04 - platform ok needs all of above, both sleep inputs, all six rails
// RULE_05 - power-good outputs drop immediately on qualifier loss or fault
// RULE_06 - supply below lower threshold resets all registers
// RULE_07 - enable falling edge resets registers unless first ldo always on
// RULE_08 - thermal trip falling edge resets registers while resume good is high
// RULE_09 - unmasked rail power fault resets all registers
// RULE_10 - critical temperature shutdown resets all registers
// RULE_11 - host writing shutdown bit one forces shutdown and register reset
// RULE_12 - idle or s3 sleep falling edge resets rail one, two voltage codes
// RULE_13 - rails three to six have a forced pwm select bit
// RULE_14 - automatic mode is the default after reset
// RULE_15 - rails one and two always stay in automatic mode
// RULE_16 - load switch follows s4 for low-power memory, s3 otherwise
// RULE_17 - reset conditions ORed into one synchronous pulse after synchronised edges
// -----------------------------------------------------------------------------
`include "pgrr_params.svh"

module pgrr_top
#(
    parameter int NR = `PGRR_NUM_RAILS,
    parameter int NF = `PGRR_NUM_FAULTS,
    parameter int VW = `PGRR_VCODE_W,
    parameter int DW = `PGRR_DISCH_W
)
(
    input  wire logic             I_CLK,
    input  wire logic             I_RESET,
    input  wire logic             I_SUPPLY_LOCKOUT_CLEAR,
    input  wire logic             I_SUPPLY_BELOW_RESET,
    input  wire logic             I_CHIP_ENABLE_IN,
    input  wire logic             I_THERMAL_TRIP_N,
    input  wire logic             I_SLEEP_STATE_FOUR_N,
    input  wire logic             I_SLEEP_STATE_THREE_N,
    input  wire logic             I_LOW_POWER_IDLE_N,
    input  wire logic [NR-1:0]    I_RAIL_GOOD,
    input  wire logic [NF-1:0]    I_RAIL_FAULT,
    input  wire logic             I_CRIT_TEMP,
    input  wire logic             I_FIRST_LDO_ALWAYS_ON,
    input  wire logic             I_MEM_LOW_POWER,
    input  wire logic [NR-1:0]    I_RAIL_ENABLE,
    input  wire logic             I_CFG_WR,
    input  wire logic             I_CFG_SOFT_SHUTDOWN_BIT,
    input  wire logic [NF-1:0]    I_CFG_FAULT_MASK,
    input  wire logic [NR-1:0]    I_CFG_PWM_FORCE,
    input  wire logic [NR*DW-1:0] I_CFG_DISCHARGE_SEL,
    input  wire logic             I_CFG_VCODE_WR,
    input  wire logic [VW-1:0]    I_CFG_VCODE_ONE,
    input  wire logic [VW-1:0]    I_CFG_VCODE_TWO,
    output logic                  O_RESUME_RESET_GOOD_N,
    output logic                  O_PLATFORM_POWER_OK,
    output logic                  O_REG_RESET,
    output logic                  O_SOFT_SHUTDOWN,
    output logic [NR-1:0]         O_DISCHARGE_ON,
    output logic [NR*DW-1:0]      O_DISCHARGE_SEL,
    output logic [NR-1:0]         O_RAIL_PWM_FORCE,
    output logic [NF-1:0]         O_FAULT_MASK,
    output logic [VW-1:0]         O_VCODE_ONE,
    output logic [VW-1:0]         O_VCODE_TWO,
    output logic                  O_COMBINED_LOAD_SWITCH,
    output logic [2:0]            O_STATE
);

    localparam int SW = 11 + NR + NF;

    logic [SW-1:0]   raw_in;
    logic [SW-1:0]   syn;
    logic            lockout_clr;
    logic            below_rst;
    logic            chip_en;
    logic            therm_n;
    logic            s4_n;
    logic            s3_n;
    logic            idle_n;
    logic            crit_temp;
    logic            ldo_always;
    logic            mem_lp;
    logic [NR-1:0]   rail_good;
    logic [NF-1:0]   rail_fault;
    logic            chip_en_d_ff;
    logic            therm_n_d_ff;
    logic            s3_n_d_ff;
    logic            idle_n_d_ff;
    logic            nxt_resume;
    logic            nxt_pwrok;
    logic            any_fault;
    logic            reset_cond;
    logic            shutdown_req_ff;
    logic            reg_reset_ff;
    logic            vcode_reset;
    pgrr_pkg::pgrr_state_e state_ff;
    pgrr_pkg::pgrr_state_e nxt_state;

    // -------------------------------------------------------------------------
    // input synchronisers
    // -------------------------------------------------------------------------
    // config ports come from local logic and are not synchronised
    assign raw_in = {I_SUPPLY_LOCKOUT_CLEAR, I_SUPPLY_BELOW_RESET, I_CHIP_ENABLE_IN,
                     I_THERMAL_TRIP_N, I_SLEEP_STATE_FOUR_N, I_SLEEP_STATE_THREE_N,
                     I_LOW_POWER_IDLE_N, I_CRIT_TEMP, I_FIRST_LDO_ALWAYS_ON,
                     I_MEM_LOW_POWER, 1'b0, I_RAIL_GOOD, I_RAIL_FAULT};

    pgrr_sync #(.WIDTH(SW)) u_sync
    (
        .I_CLK     (I_CLK),
        .I_RESET   (I_RESET),
        .i_async   (raw_in),
        .o_sync    (syn)
    );

    assign lockout_clr = syn[SW-1];
    assign below_rst   = syn[SW-2];
    assign chip_en     = syn[SW-3];
    assign therm_n     = syn[SW-4];
    assign s4_n        = syn[SW-5];
    assign s3_n        = syn[SW-6];
    assign idle_n      = syn[SW-7];
    assign crit_temp   = syn[SW-8];
    assign ldo_always  = syn[SW-9];
    assign mem_lp      = syn[SW-10];
    assign rail_good   = syn[NF +: NR];
    assign rail_fault  = syn[NF-1:0];

    // -------------------------------------------------------------------------
    // edge detection
    // -------------------------------------------------------------------------
    always_ff @(posedge I_CLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            chip_en_d_ff <= 1'b0;
            therm_n_d_ff <= 1'b0;
            s3_n_d_ff    <= 1'b0;
            idle_n_d_ff  <= 1'b0;
        end
        else
        begin
            chip_en_d_ff <= chip_en;
            therm_n_d_ff <= therm_n;
            s3_n_d_ff    <= s3_n;
            idle_n_d_ff  <= idle_n;
        end
    end

    function automatic logic fell(input logic prev, input logic cur);
        fell = prev & ~cur;
    endfunction

    // -------------------------------------------------------------------------
    // power good qualification
    // -------------------------------------------------------------------------
    assign any_fault = |(rail_fault & ~O_FAULT_MASK) | crit_temp | below_rst;

    always_comb
    begin
        nxt_resume = lockout_clr & chip_en & therm_n
                   & rail_good[`PGRR_R1] & rail_good[`PGRR_R4]
                   & rail_good[`PGRR_R5]
                   & ~any_fault & ~reset_cond;                      // RULE_03
        nxt_pwrok  = nxt_resume & s4_n & s3_n & (&rail_good);      // RULE_04
    end

    // no extra filtering: a lost qualifier drops the output next edge
    always_ff @(posedge I_CLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            O_RESUME_RESET_GOOD_N <= 1'b0;
            O_PLATFORM_POWER_OK   <= 1'b0;
        end
        else
        begin
            O_RESUME_RESET_GOOD_N <= nxt_resume;                    // RULE_05
            O_PLATFORM_POWER_OK   <= nxt_pwrok;                     // RULE_05
        end
    end

    // -------------------------------------------------------------------------
    // sequencer state
    // -------------------------------------------------------------------------
    always_comb
    begin
        unique case (state_ff)
            pgrr_pkg::PGRR_OFF:    nxt_state = nxt_resume ? pgrr_pkg::PGRR_RESUME
                                                          : pgrr_pkg::PGRR_OFF;
            pgrr_pkg::PGRR_RESUME: nxt_state = !nxt_resume ? pgrr_pkg::PGRR_OFF
                                             : nxt_pwrok ? pgrr_pkg::PGRR_ACTIVE
                                                         : pgrr_pkg::PGRR_RESUME;
            pgrr_pkg::PGRR_ACTIVE: nxt_state = !nxt_resume ? pgrr_pkg::PGRR_OFF
                                             : !nxt_pwrok ? pgrr_pkg::PGRR_RESUME
                                                          : pgrr_pkg::PGRR_ACTIVE;
            default:               nxt_state = pgrr_pkg::PGRR_OFF;
        endcase
    end

    always_ff @(posedge I_CLK or posedge I_RESET)
    begin
        if (I_RESET)
            state_ff <= pgrr_pkg::PGRR_OFF;
        else
            state_ff <= nxt_state;
    end

    always_ff @(posedge I_CLK or posedge I_RESET)
    begin
        if (I_RESET)
            O_STATE <= pgrr_pkg::PGRR_OFF;
        else
            O_STATE <= nxt_state;
    end

    // -------------------------------------------------------------------------
    // register reset generation
    // -------------------------------------------------------------------------
    // shutdown request is a registered copy of the write strobe gated by the shutdown bit; it stays high as long as the write did, one cycle later
    always_ff @(posedge I_CLK or posedge I_RESET)
    begin
        if (I_RESET)
            shutdown_req_ff <= 1'b0;
        else
            shutdown_req_ff <= I_CFG_WR & I_CFG_SOFT_SHUTDOWN_BIT;  // RULE_11
    end

    always_comb
    begin
        reset_cond = below_rst                                       // RULE_06
                   | (fell(chip_en_d_ff, chip_en) & ~ldo_always)     // RULE_07
                   | (fell(therm_n_d_ff, therm_n)
                      & O_RESUME_RESET_GOOD_N)                       // RULE_08
                   | (|(rail_fault & ~O_FAULT_MASK))                 // RULE_09
                   | crit_temp                                       // RULE_10
                   | shutdown_req_ff;                                // RULE_11
    end

    always_ff @(posedge I_CLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            reg_reset_ff    <= 1'b1;
            O_REG_RESET     <= 1'b1;
            O_SOFT_SHUTDOWN <= 1'b0;
        end
        else
        begin
            reg_reset_ff    <= reset_cond;                           // RULE_17
            O_REG_RESET     <= reset_cond;                           // RULE_17
            O_SOFT_SHUTDOWN <= shutdown_req_ff;                      // RULE_11
        end
    end

    // -------------------------------------------------------------------------
    // configuration registers
    // -------------------------------------------------------------------------
    // global reset beats a write landing on the same edge
    always_ff @(posedge I_CLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            O_FAULT_MASK     <= `PGRR_MASK_RST;
            O_RAIL_PWM_FORCE <= {NR{1'b0}};
            O_DISCHARGE_SEL  <= {NR{`PGRR_DISCH_RST}};
        end
        else if (reg_reset_ff)
        begin
            O_FAULT_MASK     <= `PGRR_MASK_RST;                      // RULE_17
            O_RAIL_PWM_FORCE <= {NR{1'b0}};                          // RULE_14
            O_DISCHARGE_SEL  <= {NR{`PGRR_DISCH_RST}};
        end
        else if (I_CFG_WR)
        begin
            O_FAULT_MASK     <= I_CFG_FAULT_MASK;
            O_RAIL_PWM_FORCE <= {I_CFG_PWM_FORCE[NR-1:`PGRR_R3], 2'b00}; // RULE_13 RULE_15
            O_DISCHARGE_SEL  <= I_CFG_DISCHARGE_SEL;                 // RULE_02
        end
    end

    // -------------------------------------------------------------------------
    // voltage codes of rails one and two
    // -------------------------------------------------------------------------
    assign vcode_reset = reg_reset_ff | fell(idle_n_d_ff, idle_n)
                       | fell(s3_n_d_ff, s3_n);                      // RULE_12

    always_ff @(posedge I_CLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            O_VCODE_ONE <= `PGRR_VCODE_RST;
            O_VCODE_TWO <= `PGRR_VCODE_RST;
        end
        else if (vcode_reset)
        begin
            O_VCODE_ONE <= `PGRR_VCODE_RST;                          // RULE_12
            O_VCODE_TWO <= `PGRR_VCODE_RST;
        end
        else if (I_CFG_VCODE_WR)
        begin
            O_VCODE_ONE <= I_CFG_VCODE_ONE;
            O_VCODE_TWO <= I_CFG_VCODE_TWO;
        end
    end

    // -------------------------------------------------------------------------
    // discharge and load switch
    // -------------------------------------------------------------------------
    always_ff @(posedge I_CLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            O_DISCHARGE_ON         <= {NR{1'b1}};
            O_COMBINED_LOAD_SWITCH <= 1'b0;
        end
        else
        begin
            O_DISCHARGE_ON         <= ~I_RAIL_ENABLE;                // RULE_01
            O_COMBINED_LOAD_SWITCH <= (mem_lp == `PGRR_MEM_LP) ? s4_n : s3_n; // RULE_16
        end
    end

endmodule // pgrr_top

// >>> tb/pgrr_top_sva.sv
// concurrent checks on the ports of the power-good and register-reset block
`include "pgrr_params.svh"
module pgrr_top_sva
#(
    parameter int NR = `PGRR_NUM_RAILS,
    parameter int NF = `PGRR_NUM_FAULTS
)
(
    input wire logic          I_CLK,
    input wire logic          I_RESET,
    input wire logic          I_SUPPLY_LOCKOUT_CLEAR,
    input wire logic          I_SUPPLY_BELOW_RESET,
    input wire logic          I_CHIP_ENABLE_IN,
    input wire logic          I_THERMAL_TRIP_N,
    input wire logic          I_SLEEP_STATE_FOUR_N,
    input wire logic          I_SLEEP_STATE_THREE_N,
    input wire logic [NR-1:0] I_RAIL_GOOD,
    input wire logic [NF-1:0] I_RAIL_FAULT,
    input wire logic          I_CRIT_TEMP,
    input wire logic [NR-1:0] I_RAIL_ENABLE,
    input wire logic          I_CFG_WR,
    input wire logic          I_CFG_SOFT_SHUTDOWN_BIT,
    input wire logic          O_RESUME_RESET_GOOD_N,
    input wire logic          O_PLATFORM_POWER_OK,
    input wire logic          O_REG_RESET,
    input wire logic          O_SOFT_SHUTDOWN,
    input wire logic [NR-1:0] O_DISCHARGE_ON,
    input wire logic [NF-1:0] O_FAULT_MASK
);
    timeunit 1ns;
    timeprecision 1ns;
    // -------------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------------
    logic [2:0] age_ff;
    wire core_ok = I_SUPPLY_LOCKOUT_CLEAR && I_CHIP_ENABLE_IN && I_THERMAL_TRIP_N;
    wire res_q = core_ok && I_RAIL_GOOD[0] && I_RAIL_GOOD[3] && I_RAIL_GOOD[4];
    wire all_ok = core_ok && I_SLEEP_STATE_FOUR_N && I_SLEEP_STATE_THREE_N && &I_RAIL_GOOD;
    wire rail_fault = |(I_RAIL_FAULT & ~O_FAULT_MASK);

    // history before release is stale, so edge checks wait a few cycles
    always_ff @(posedge I_CLK or posedge I_RESET)
    begin
        if (I_RESET)
            age_ff <= 3'h0;
        else if (age_ff != 3'h7)
            age_ff <= age_ff + 3'h1;
    end

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RESET);

    // -------------------------------------------------------------------------
    // properties
    // -------------------------------------------------------------------------
    sequence s_sd_req;
        I_CFG_WR && I_CFG_SOFT_SHUTDOWN_BIT && !O_REG_RESET;
    endsequence
    sequence s_sd_act;
        ##2 (O_REG_RESET && O_SOFT_SHUTDOWN) ##1 (!O_SOFT_SHUTDOWN && !O_REG_RESET && ~|O_FAULT_MASK);
    endsequence
    property p_disch;
        age_ff != 3'h0 && !$past(O_REG_RESET) |-> O_DISCHARGE_ON == ~$past(I_RAIL_ENABLE);
    endproperty
    property p_res_rise;
        age_ff == 3'h7 && $rose(O_RESUME_RESET_GOOD_N) |-> $past(res_q, 3);
    endproperty
    property p_pok_rise;
        age_ff == 3'h7 && $rose(O_PLATFORM_POWER_OK) |-> $past(all_ok, 3);
    endproperty
    property p_core_lost;
        !core_ok |-> ##3 (!O_RESUME_RESET_GOOD_N && !O_PLATFORM_POWER_OK);
    endproperty
    property p_pok_lost;
        !all_ok |-> ##3 !O_PLATFORM_POWER_OK;
    endproperty
    property p_level_rst;
        I_SUPPLY_BELOW_RESET || I_CRIT_TEMP |-> ##[2:4] O_REG_RESET;
    endproperty
    property p_fault_rst;
        rail_fault |-> ##[2:4] O_REG_RESET;
    endproperty
    property p_soft_shutdown_bit;
        s_sd_req |-> s_sd_act;
    endproperty

    a_disch: assert property (p_disch) else $error("discharge mismatch");
    a_res_rise: assert property (p_res_rise) else $error("resume rose early");
    a_pok_rise: assert property (p_pok_rise) else $error("power ok rose early");
    a_core_lost: assert property (p_core_lost) else $error("goods kept");
    a_pok_lost: assert property (p_pok_lost) else $error("power ok kept");
    a_level_rst: assert property (p_level_rst) else $error("no level reset");
    a_fault_rst: assert property (p_fault_rst) else $error("no fault reset");
    a_soft_shutdown_bit: assert property (p_soft_shutdown_bit) else $error("shutdown sequence wrong");
endmodule // pgrr_top_sva

// >>> tb/pgrr_host_model.sv
// platform controller model driving the sleep-state lines
module pgrr_host_model
(
    input  wire logic       i_clk,
    input  wire logic [2:0] i_cmd,
    input  wire logic [2:0] i_lag,
    output logic      [2:0] o_sleep_n
);
    timeunit 1ns;
    timeprecision 1ns;
    // -------------------------------------------------------------------------
    // line sequencing, bit2 s4, bit1 s3, bit0 idle
    // -------------------------------------------------------------------------
    logic [2:0] wait_ff = 3'h0;
    logic [2:0] cmd_ff  = 3'h0;

    // a lag stands for a slow controller that answers late
    // command taken on the rising edge so a falling-edge change cannot race
    initial o_sleep_n = 3'h0;
    always @(posedge i_clk) cmd_ff <= i_cmd;
    always @(negedge i_clk)
    begin
        if (cmd_ff == o_sleep_n)
            wait_ff <= 3'h0;
        else if (wait_ff >= i_lag)
            o_sleep_n <= cmd_ff;
        else
            wait_ff <= wait_ff + 3'h1;
    end
endmodule // pgrr_host_model

// >>> tb/pgrr_top_tb.sv
// self-checking bench for the power-good and register-reset block
`include "pgrr_params.svh"
module pgrr_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst, lock, below, en, therm, crit, ldo_on, mem_lp, wr, sd, vwr;
    logic [5:0]  good, ren, pwm, o_don, o_pwm;
    logic [11:0] flt, mask, dsel, o_dsel, o_mask;
    logic [6:0]  v1, v2, o_v1, o_v2;
    logic [2:0]  cmd, lag, slp, o_st;
    logic        o_res, o_pok, o_rr, o_sd, o_sw;
    int          error_cnt, total_checks, rr_cnt, sd_cnt, n;

    pgrr_top u_pgrr_top
    (
        .I_CLK(clk), .I_RESET(rst), .I_SUPPLY_LOCKOUT_CLEAR(lock),
        .I_SUPPLY_BELOW_RESET(below), .I_CHIP_ENABLE_IN(en), .I_THERMAL_TRIP_N(therm),
        .I_SLEEP_STATE_FOUR_N(slp[2]), .I_SLEEP_STATE_THREE_N(slp[1]),
        .I_LOW_POWER_IDLE_N(slp[0]), .I_RAIL_GOOD(good), .I_RAIL_FAULT(flt),
        .I_CRIT_TEMP(crit), .I_FIRST_LDO_ALWAYS_ON(ldo_on), .I_MEM_LOW_POWER(mem_lp),
        .I_RAIL_ENABLE(ren), .I_CFG_WR(wr), .I_CFG_SOFT_SHUTDOWN_BIT(sd),
        .I_CFG_FAULT_MASK(mask), .I_CFG_PWM_FORCE(pwm), .I_CFG_DISCHARGE_SEL(dsel),
        .I_CFG_VCODE_WR(vwr), .I_CFG_VCODE_ONE(v1), .I_CFG_VCODE_TWO(v2),
        .O_RESUME_RESET_GOOD_N(o_res), .O_PLATFORM_POWER_OK(o_pok), .O_REG_RESET(o_rr),
        .O_SOFT_SHUTDOWN(o_sd), .O_DISCHARGE_ON(o_don), .O_DISCHARGE_SEL(o_dsel),
        .O_RAIL_PWM_FORCE(o_pwm), .O_FAULT_MASK(o_mask), .O_VCODE_ONE(o_v1),
        .O_VCODE_TWO(o_v2), .O_COMBINED_LOAD_SWITCH(o_sw), .O_STATE(o_st)
    );
    pgrr_host_model u_pgrr_host_model (.i_clk(clk), .i_cmd(cmd), .i_lag(lag), .o_sleep_n(slp));

    // -------------------------------------------------------------------------
    // tasks
    // -------------------------------------------------------------------------
    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        total_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic cfg(input logic s, input logic [11:0] m, input logic [5:0] p);
        {sd, mask, pwm} = {s, m, p};
        wr = 1'b1;
        cyc(1);
        wr = 1'b0;
        cyc(4);
    endtask
    // reset cycles are counted, so a missing or an unexpected reset shows up; a stretched one does not
    task automatic rr(input logic w, input string nm);
        n = rr_cnt;
        cyc(7);
        chk(nm, 12'(w), 12'(rr_cnt != n));
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    always @(posedge clk) rr_cnt += int'(o_rr === 1'b1);
    always @(posedge clk) sd_cnt += int'(o_sd === 1'b1);
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial
    begin
        #1000000;
        error_cnt++;
        test_done;
    end

    // -------------------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------------------
    initial
    begin
        {rst, lock, below, en, therm, crit, ldo_on, mem_lp, wr, sd, vwr} = 11'h400;
        {good, ren, pwm, flt, mask, dsel, v1, v2, cmd, lag} = 74'h0;
        cyc(20);
        rst = 1'b0;
        cyc(3);
        chk("rr0", 12'h0, 12'(o_rr));
        chk("dsel0", 12'({6{`PGRR_DISCH_RST}}), o_dsel);
        chk("pwm0", 12'h0, 12'(o_pwm));
        chk("st0", 12'(pgrr_pkg::PGRR_OFF), 12'(o_st));
        {ren, dsel} = {6'h2A, 12'hA5C};
        cfg(1'b0, 12'h000, 6'h3F);
        chk("don", 12'h015, 12'(o_don));
        chk("dsel", 12'hA5C, o_dsel);
        chk("pwm", 12'h03C, 12'(o_pwm));
        {lock, en, therm, good} = {3'h7, 6'h19};
        cyc(6);
        chk("res", 12'h1, 12'(o_res));
        chk("pok", 12'h0, 12'(o_pok));
        chk("st", 12'(pgrr_pkg::PGRR_RESUME), 12'(o_st));
        {good, cmd, lag} = {6'h3F, 3'h7, 3'h4};
        cyc(12);
        chk("pok", 12'h1, 12'(o_pok));
        for (int i = 0; i < 6; i++)
        begin
            good[i] = 1'b0;
            cyc(4);
            chk("pok_rail", 12'h0, 12'(o_pok));
            chk("res_rail", 12'(i != 0 && i != 3 && i != 4), 12'(o_res));
            good[i] = 1'b1;
            cyc(4);
        end
        lock = 1'b0;
        cyc(4);
        chk("res_lock", 12'h0, 12'(o_res));
        lock = 1'b1;
        for (int k = 0; k < 2; k++)
        begin
            cmd = 3'h7;
            cyc(10);
            {v1, v2, vwr} = {7'h33, 7'h5A, 1'b1};
            cyc(1);
            vwr = 1'b0;
            cyc(2);
            chk("v1", 12'h033, 12'(o_v1));
            chk("v2", 12'h05A, 12'(o_v2));
            cmd = (k == 0) ? 3'h6 : 3'h5;
            cyc(10);
            chk("v1z", 12'h0, 12'(o_v1));
            chk("v2z", 12'h0, 12'(o_v2));
            chk("pok_s", 12'(k == 0), 12'(o_pok));
        end
        for (int j = 0; j < 4; j++)
        begin
            {cmd, mem_lp} = {j[1] ? 3'h3 : 3'h5, j[0]};
            cyc(10);
            chk("sw", 12'(mem_lp ? cmd[2] : cmd[1]), 12'(o_sw));
        end
        cmd = 3'h7;
        for (int t = 0; t < 2; t++)
        begin
            good = t ? 6'h3F : 6'h3E;
            cyc(10);
            therm = 1'b0;
            rr(t[0], "rr_therm");
            therm = 1'b1;
        end
        for (int t = 0; t < 2; t++)
        begin
            ldo_on = !t[0];
            cyc(6);
            en = 1'b0;
            rr(t[0], "rr_en");
            en = 1'b1;
        end
        cfg(1'b0, 12'h004, 6'h00);
        flt = 12'h004;
        rr(1'b0, "rr_mask");
        for (int c = 0; c < 3; c++)
        begin
            {below, crit, flt} = {c == 0, c == 1, (c == 2) ? 12'h008 : 12'h000};
            rr(1'b1, "rr_lvl");
            {below, crit, flt} = 14'h0000;
            cyc(6);
        end
        cfg(1'b0, 12'hFFF, 6'h3F);
        chk("mask", 12'hFFF, o_mask);
        n = rr_cnt;
        cfg(1'b1, 12'hFFF, 6'h3F);
        chk("sd", 12'h1, 12'(sd_cnt));
        chk("rr_sd", 12'h1, 12'(rr_cnt - n));
        chk("mask_sd", 12'h0, o_mask);
        chk("pwm_sd", 12'h0, 12'(o_pwm));
        test_done;
    end
endmodule // pgrr_top_tb

bind pgrr_top pgrr_top_sva #(.NR(NR), .NF(NF)) u_pgrr_top_sva
(
    .I_CLK, .I_RESET, .I_SUPPLY_LOCKOUT_CLEAR, .I_SUPPLY_BELOW_RESET, .I_CHIP_ENABLE_IN,
    .I_THERMAL_TRIP_N, .I_SLEEP_STATE_FOUR_N, .I_SLEEP_STATE_THREE_N, .I_RAIL_GOOD,
    .I_RAIL_FAULT, .I_CRIT_TEMP, .I_RAIL_ENABLE, .I_CFG_WR, .I_CFG_SOFT_SHUTDOWN_BIT,
    .O_RESUME_RESET_GOOD_N, .O_PLATFORM_POWER_OK, .O_REG_RESET, .O_SOFT_SHUTDOWN,
    .O_DISCHARGE_ON, .O_FAULT_MASK
);
